// ---- design/iso_rx_ctl_map.svh ----
// Register offsets, field positions, reset values and codes for the
// isochronous receive context control block.
// Assumes inclusion by design and bench files; definitions only.
`ifndef ISO_RX_CTL_MAP_SVH
`define ISO_RX_CTL_MAP_SVH

`define CTL_SET_OFS      12'h400
`define CTL_CLR_OFS      12'h404
`define CTL_RD_OFS       12'h408
`define INT_STAT_OFS     12'h420
`define INT_CLR_OFS      12'h424
`define INT_EN_OFS       12'h428
`define EVT_IN_OFS       12'h42C

`define BIT_FILL         31
`define BIT_RUN          15
`define BIT_WAKE         12
`define BIT_DEAD         11
`define BIT_ACTIVE       10
`define SPD_LSB          5
`define EVT_LSB          0

`define SPD_S100         3'h0
`define SPD_S200         3'h1
`define SPD_S400         3'h2

`define EVC_NONE         5'h00
`define EVC_LONG_PACKET  5'h02
`define EVC_DESC_READ    5'h05
`define EVC_DATA_WRITE   5'h07
`define EVC_OVERRUN      5'h0B
`define EVC_UNKNOWN      5'h0E
`define EVC_ACK_COMPLETE 5'h11
`define EVC_ACK_DATA_ERR 5'h1D

`define INT_BITS         4
`define INT_PKT          0
`define INT_DEAD         1
`define INT_BACKOUT      2
`define INT_IDLE         3

`define AXI_OKAY         2'h0
`define AXI_SLVERR       2'h2

`endif

// ---- design/iso_rx_ctl_pkg.sv ----
// Types shared by the isochronous receive context control files.
// Assumes the map header holds all register, field and event-code constants.
package iso_rx_ctl_pkg;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_RECV  = 4'b0100,
        ST_WAIT  = 4'b1000
    } ctx_state_t;

    typedef enum logic [1:0] {
        PE_OK    = 2'h0,
        PE_DATA  = 2'h1,
        PE_LONG  = 2'h2,
        PE_OVRUN = 2'h3
    } pkt_err_t;

endpackage

// ---- design/iso_rx_evt_code.sv ----
// Maps packet outcome and buffering mode to a five-bit event code.
// Assumes inputs come from logic on the same clock.
`timescale 1ns/100ps
`include "iso_rx_ctl_map.svh"

module iso_rx_evt_code
    import iso_rx_ctl_pkg::*;
(
    input  wire logic       fill_whole_buffers_mode,
    input  pkt_err_t        pkt_err,
    input  wire logic       desc_err,
    input  wire logic       data_err,
    input  wire logic       other_err,
    output logic      [4:0] evt_code,
    output logic            back_out
);

    always_comb begin
        back_out = 1'b0;
        if (desc_err) begin
            evt_code = `EVC_DESC_READ;
        end else if (data_err) begin
            evt_code = `EVC_DATA_WRITE;
        end else if (other_err) begin
            evt_code = `EVC_UNKNOWN;
        end else if (fill_whole_buffers_mode) begin
            evt_code = `EVC_ACK_COMPLETE;
            back_out = (pkt_err != PE_OK);
        end else begin
            unique case (pkt_err)
                PE_OK:    evt_code = `EVC_ACK_COMPLETE;
                PE_DATA:  evt_code = `EVC_ACK_DATA_ERR;
                PE_LONG:  evt_code = `EVC_LONG_PACKET;
                PE_OVRUN: evt_code = `EVC_OVERRUN;
            endcase
        end
    end

endmodule

// ---- design/iso_rx_axil_slave.sv ----
// AXI4-Lite slave front end: catches one write and one read at a time.
// Assumes a master on the same clock; answers two cycles after the handshake.
`timescale 1ns/100ps

module iso_rx_axil_slave #(
    parameter int AW = 12
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    output logic               wr_pulse,
    output logic      [AW-1:0] wr_addr,
    output logic      [31:0]   wr_data,
    output logic      [3:0]    wr_strb,
    output logic               rd_pulse,
    output logic      [AW-1:0] rd_addr
);

    logic aw_have_q;
    logic w_have_q;

    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid && !rd_pulse;

    // Address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            wr_addr   <= '0;
            wr_data   <= '0;
            wr_strb   <= '0;
        end else if (wr_pulse) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                wr_addr   <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wr_data  <= s_axi_wdata;
                wr_strb  <= s_axi_wstrb;
            end
        end
    end

    assign wr_pulse = aw_have_q && w_have_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
        end else if (wr_pulse) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_pulse     <= 1'b0;
            rd_addr      <= '0;
            s_axi_rvalid <= 1'b0;
        end else begin
            rd_pulse <= s_axi_arvalid && s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                rd_addr <= s_axi_araddr;
            end
            if (rd_pulse) begin
                s_axi_rvalid <= 1'b1;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ---- design/iso_rx_ctx_ctl.sv ----
// Control and status of one isochronous receive DMA context.
// Assumes AXI4-Lite master and descriptor engine on aclk; link events are pulses.
`timescale 1ns/100ps
`include "iso_rx_ctl_map.svh"

// Notes on behaviour
// - Hardware never changes run except on hardware or software reset.
// - Bits 14 and 13 read as zero.
// - Setting wake makes the context continue or resume processing.
// - Wake clears on every descriptor fetch.
// - Dead sets on a fatal error.
// - Dead clears once software has cleared run.
// - Active stays high while descriptors are being processed.
// - Bits 9 and 8 read as zero.
// - Speed field records speed of each received packet: 000, 001, 010.
// - Fill-whole-buffers mode reports only four event codes.
// - Fill-whole-buffers mode backs out packets with errors or overrun.
// - Packet-per-buffer mode reports one of seven event codes.
// - Control register has set and clear addresses, ones act.
// - Fill mode packs packets back to back, else one per buffer.
module iso_rx_ctx_ctl
    import iso_rx_ctl_pkg::*;
#(
    parameter int AW = 12
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          soft_reset,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic [2:0]    s_axi_awprot,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic      [1:0]    s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic [2:0]    s_axi_arprot,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic      [31:0]   s_axi_rdata,
    output logic      [1:0]    s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    output logic               desc_fetch_req,
    input  wire logic          desc_fetch_done,
    input  wire logic          desc_avail,
    input  wire logic          pkt_done,
    input  wire logic [2:0]    pkt_speed,
    input  pkt_err_t           pkt_err,
    input  wire logic          desc_err,
    input  wire logic          data_err,
    input  wire logic          other_err,
    input  wire logic          fatal_err,
    output logic               fill_whole_buffers_mode,
    output logic               pkt_back_out,
    output logic               irq
);

    logic          wr_pulse;
    logic [AW-1:0] wr_addr;
    logic [31:0]   wr_data;
    logic [3:0]    wr_strb;
    logic          rd_pulse;
    logic [AW-1:0] rd_addr;
    logic [31:0]   wmask;

    logic          run_q;
    logic          wake_q;
    logic          dead_q;
    logic          fill_q;
    logic [2:0]    spd_q;
    logic [4:0]    evt_q;
    logic [4:0]    evt_code;
    logic          back_out;
    logic [3:0]    int_stat_q;
    logic [3:0]    int_en_q;
    logic [3:0]    int_set;
    logic          active;
    logic          sw_set;
    logic          sw_clr;
    ctx_state_t    st_q;
    ctx_state_t    st_d;

    iso_rx_axil_slave #(
        .AW (AW)
    ) u_bus (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_pulse      (wr_pulse),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .rd_pulse      (rd_pulse),
        .rd_addr       (rd_addr)
    );

    iso_rx_evt_code u_evt (
        .fill_whole_buffers_mode (fill_q),
        .pkt_err                 (pkt_err),
        .desc_err                (desc_err),
        .data_err                (data_err),
        .other_err               (other_err),
        .evt_code                (evt_code),
        .back_out                (back_out)
    );

    // Byte enables widened to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic is_reg(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
        is_reg = (a == ofs);
    endfunction

    assign wmask  = wr_data & strb_mask(wr_strb);
    assign sw_set = wr_pulse && is_reg(wr_addr, AW'(`CTL_SET_OFS));
    assign sw_clr = wr_pulse && is_reg(wr_addr, AW'(`CTL_CLR_OFS));

    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            run_q <= 1'b0;
        end else if (sw_set && wmask[`BIT_RUN]) begin
            run_q <= 1'b1;
        end else if (sw_clr && wmask[`BIT_RUN]) begin
            run_q <= 1'b0;
        end
    end

    // Mode must not change while running; a stray write is simply dropped
    // Fill mode select
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            fill_q <= 1'b0;
        end else if (!run_q && !active) begin
            if (sw_set && wmask[`BIT_FILL]) begin
                fill_q <= 1'b1;
            end else if (sw_clr && wmask[`BIT_FILL]) begin
                fill_q <= 1'b0;
            end
        end
    end

    assign fill_whole_buffers_mode = fill_q;

    // Fetch clears wake; fetch wins over a set in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            wake_q <= 1'b0;
        end else if (desc_fetch_done) begin
            wake_q <= 1'b0;
        end else if (sw_set && wmask[`BIT_WAKE]) begin
            wake_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            dead_q <= 1'b0;
        end else if (fatal_err && run_q) begin
            dead_q <= 1'b1;
        end else if (!run_q) begin
            dead_q <= 1'b0;
        end
    end

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: begin
                if (run_q && !dead_q) begin
                    st_d = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (desc_fetch_done) begin
                    st_d = desc_avail ? ST_RECV : ST_WAIT;
                end
            end
            ST_RECV: begin
                if (pkt_done) begin
                    st_d = ST_FETCH;
                end
            end
            ST_WAIT: begin
                if (wake_q) begin
                    st_d = ST_FETCH;
                end
            end
        endcase
        if (!run_q || dead_q || fatal_err) begin
            st_d = ST_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign active         = (st_q == ST_FETCH) || (st_q == ST_RECV);
    assign desc_fetch_req = (st_q == ST_FETCH);

    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            spd_q        <= `SPD_S100;
            evt_q        <= `EVC_NONE;
            pkt_back_out <= 1'b0;
        end else begin
            pkt_back_out <= pkt_done && (st_q == ST_RECV) && back_out;
            if (pkt_done && st_q == ST_RECV) begin
                spd_q <= pkt_speed;
                evt_q <= evt_code;
            end
        end
    end

    assign int_set[`INT_PKT]     = pkt_done && (st_q == ST_RECV);
    assign int_set[`INT_DEAD]    = fatal_err && run_q && !dead_q;
    assign int_set[`INT_BACKOUT] = pkt_done && (st_q == ST_RECV) && back_out;
    assign int_set[`INT_IDLE]    = desc_fetch_done && !desc_avail && (st_q == ST_FETCH);

    // Set wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_stat_q <= '0;
            int_en_q   <= '0;
        end else begin
            if (wr_pulse && is_reg(wr_addr, AW'(`INT_CLR_OFS))) begin
                int_stat_q <= (int_stat_q & ~wmask[3:0]) | int_set;
            end else begin
                int_stat_q <= int_stat_q | int_set;
            end
            if (wr_pulse && is_reg(wr_addr, AW'(`INT_EN_OFS))) begin
                int_en_q <= wr_strb[0] ? wr_data[3:0] : int_en_q;
            end
        end
    end

    assign irq = |(int_stat_q & int_en_q);

    assign s_axi_bresp = `AXI_OKAY;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= '0;
            s_axi_rresp <= `AXI_OKAY;
        end else if (rd_pulse) begin
            s_axi_rresp <= `AXI_OKAY;
            s_axi_rdata <= '0;
            if (is_reg(rd_addr, AW'(`CTL_SET_OFS)) || is_reg(rd_addr, AW'(`CTL_CLR_OFS))
                || is_reg(rd_addr, AW'(`CTL_RD_OFS))) begin
                s_axi_rdata[`BIT_FILL]           <= fill_q;
                s_axi_rdata[`BIT_RUN]            <= run_q;
                s_axi_rdata[`BIT_WAKE]           <= wake_q;
                s_axi_rdata[`BIT_DEAD]           <= dead_q;
                s_axi_rdata[`BIT_ACTIVE]         <= active;
                s_axi_rdata[`SPD_LSB +: 3]       <= spd_q;
                s_axi_rdata[`EVT_LSB +: 5]       <= evt_q;
            end else if (is_reg(rd_addr, AW'(`INT_STAT_OFS))) begin
                s_axi_rdata[3:0] <= int_stat_q;
            end else if (is_reg(rd_addr, AW'(`INT_EN_OFS))) begin
                s_axi_rdata[3:0] <= int_en_q;
            end else if (!is_reg(rd_addr, AW'(`INT_CLR_OFS))) begin
                s_axi_rresp <= `AXI_SLVERR;
            end
        end
    end

endmodule

// ---- bench/iso_rx_ctx_ctl_properties.sv ----
// Port-level checks for the receive context control block.
// Assumes binding to iso_rx_ctx_ctl; one clock, synchronous active-low reset.
`timescale 1ns/100ps
`include "iso_rx_ctl_map.svh"
module iso_rx_ctx_ctl_checker
    import iso_rx_ctl_pkg::*;
(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       soft_reset,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       desc_fetch_req,
    input wire logic       desc_fetch_done,
    input wire logic       desc_avail,
    input wire logic       pkt_done,
    input pkt_err_t        pkt_err,
    input wire logic       fatal_err,
    input wire logic       fill_whole_buffers_mode,
    input wire logic       pkt_back_out
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late or early");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
        else $error("read answer late or early");
    a_bresp_okay: assert property (
        s_axi_bvalid |-> s_axi_bresp == `AXI_OKAY) else $error("write response not okay");
    a_backout_error: assert property (
        pkt_done && fill_whole_buffers_mode && pkt_err != PE_OK |=> pkt_back_out)
        else $error("bad packet not backed out");
    a_backout_cause: assert property (
        pkt_back_out |-> $past(pkt_done) && $past(fill_whole_buffers_mode)
        && $past(pkt_err) != PE_OK) else $error("back out without cause");
    a_fatal_halts: assert property (
        fatal_err |=> !desc_fetch_req) else $error("fetch goes on after fatal error");
    a_empty_waits: assert property (
        desc_fetch_done && !desc_avail && !fatal_err |=> !desc_fetch_req)
        else $error("fetch goes on with no descriptor");
    a_fill_frozen: assert property (
        desc_fetch_req && !soft_reset |=> $stable(fill_whole_buffers_mode))
        else $error("fill mode changed while processing");
    a_soft_reset_clears: assert property (
        soft_reset |=> !desc_fetch_req && !fill_whole_buffers_mode)
        else $error("soft reset left context running");

    cover property (pkt_done && fill_whole_buffers_mode && pkt_err != PE_OK ##1 pkt_back_out);
    cover property (desc_fetch_done && !desc_avail);
    cover property (fatal_err ##1 !desc_fetch_req);
endmodule

bind iso_rx_ctx_ctl iso_rx_ctx_ctl_checker u_chk (
    .aclk(aclk), .aresetn(aresetn), .soft_reset(soft_reset),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .desc_fetch_req(desc_fetch_req), .desc_fetch_done(desc_fetch_done),
    .desc_avail(desc_avail), .pkt_done(pkt_done), .pkt_err(pkt_err), .fatal_err(fatal_err),
    .fill_whole_buffers_mode(fill_whole_buffers_mode), .pkt_back_out(pkt_back_out)
);

// ---- bench/tb_top.sv ----
// Self-checking bench for the receive context control block.
// Assumes design files and map header compiled first; drives all ports itself.
`timescale 1ns/100ps
`include "iso_rx_ctl_map.svh"
module tb_top
    import iso_rx_ctl_pkg::*;
;
    logic        aclk, aresetn, soft_reset, bo;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [2:0]  pkt_speed, sp;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic [4:0]  ev;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        desc_fetch_req, desc_fetch_done, desc_avail, pkt_done, desc_err, data_err;
    logic        other_err, fatal_err, fill_whole_buffers_mode, pkt_back_out, irq;
    pkt_err_t    pkt_err;
    int          n_mismatch, check_count;
    logic [4:0]  evt_tab [7] = '{`EVC_ACK_COMPLETE, `EVC_ACK_DATA_ERR, `EVC_LONG_PACKET,
                                 `EVC_OVERRUN, `EVC_DESC_READ, `EVC_DATA_WRITE, `EVC_UNKNOWN};

    iso_rx_ctx_ctl dut (
        .aclk(aclk), .aresetn(aresetn), .soft_reset(soft_reset),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .desc_fetch_req(desc_fetch_req),
        .desc_fetch_done(desc_fetch_done), .desc_avail(desc_avail), .pkt_done(pkt_done),
        .pkt_speed(pkt_speed), .pkt_err(pkt_err), .desc_err(desc_err), .data_err(data_err),
        .other_err(other_err), .fatal_err(fatal_err), .irq(irq),
        .fill_whole_buffers_mode(fill_whole_buffers_mode), .pkt_back_out(pkt_back_out)
    );

    // Expected control word from the last packet's speed and event code
    function automatic logic [31:0] ctl(logic f, logic r, logic w, logic d, logic a);
        return {f, 15'h0, r, 2'h0, w, d, a, 2'h0, sp, ev};
    endfunction

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Both halves offered together; each released at its own ready
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        {aw_ok, w_ok} = 2'h0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awready && !aw_ok) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !w_ok) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rr = s_axi_rresp;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
        axi_read(a);
        check(nm, e, rd);
        check("rresp", {30'h0, `AXI_OKAY}, {30'h0, rr});
    endtask

    task automatic fetch(input logic av);
        desc_fetch_done <= 1'b1;
        desc_avail      <= av;
        @(posedge aclk);
        desc_fetch_done <= 1'b0;
    endtask

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Whole run is a few hundred cycles; this is ample margin
    initial begin
        #200us;
        n_mismatch++;
        $display("ERROR watchdog expected finish seen timeout");
        conclude();
    end

    initial begin
        {aresetn, soft_reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, desc_fetch_done, desc_avail, pkt_done, desc_err, data_err} = '0;
        {other_err, fatal_err, s_axi_awaddr, s_axi_araddr, s_axi_wdata, pkt_speed} = '0;
        {sp, ev} = '0;
        pkt_err = PE_OK;
        s_axi_wstrb = 4'hF;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(`CTL_RD_OFS, 32'h0, "ctl reset");
        rd_chk(`INT_EN_OFS, 32'h0, "int enable reset");
        axi_read(12'h42C);
        check("unmapped", {`AXI_SLVERR, 30'h0}, {rr, rd[29:0]});
        $display("Test reset and map done");
        for (int m = 1; m >= 0; m--) begin
            axi_write(`CTL_SET_OFS, {m[0], 31'h0});
            axi_write(`CTL_SET_OFS, 32'h0000_E300);
            axi_write(`CTL_CLR_OFS, 32'h8000_0000);
            rd_chk(`CTL_RD_OFS, ctl(m[0], 1, 0, 0, 1), "ctl running");
            for (int k = 0; k < 7; k++) begin
                fetch(1'b1);
                pkt_done  <= 1'b1;
                pkt_speed <= 3'(k % 3);
                pkt_err   <= (k < 4) ? pkt_err_t'(k[1:0]) : PE_OK;
                {desc_err, data_err, other_err} <= {k == 4, k == 5, k == 6};
                @(posedge aclk);
                pkt_done <= 1'b0;
                #1 bo = pkt_back_out;
                check("back out", {31'h0, m[0] && k inside {[1:3]}}, {31'h0, bo});
                {sp, ev} = {3'(k % 3), evt_tab[k]};
                @(posedge aclk);
                axi_read(`CTL_RD_OFS);
                if (m == 1 && k inside {[1:3]}) begin
                    check("fill event", 32'h1, {31'h0, rd[4:0] inside {`EVC_ACK_COMPLETE,
                        `EVC_DESC_READ, `EVC_DATA_WRITE, `EVC_UNKNOWN}});
                    ev = `EVC_ACK_COMPLETE;
                end
                check("ctl packet", ctl(m[0], 1, 0, 0, 1), rd);
            end
            axi_write(`CTL_CLR_OFS, 32'h0000_8000);
            axi_write(`CTL_CLR_OFS, 32'h8000_0000);
            rd_chk(`CTL_RD_OFS, ctl(0, 0, 0, 0, 0), "ctl stopped");
            $display("Test mode %0d done", m);
        end
        axi_write(`CTL_SET_OFS, 32'h0000_8000);
        fetch(1'b0);
        @(posedge aclk);
        check("fetch waiting", 32'h0, {31'h0, desc_fetch_req});
        rd_chk(`CTL_RD_OFS, ctl(0, 1, 0, 0, 0), "ctl waiting");
        axi_write(`CTL_SET_OFS, 32'h0000_1000);
        @(posedge aclk);
        check("fetch woken", 32'h1, {31'h0, desc_fetch_req});
        axi_write(`CTL_SET_OFS, 32'h0000_1000);
        rd_chk(`CTL_RD_OFS, ctl(0, 1, 1, 0, 1), "ctl wake set");
        fetch(1'b1);
        rd_chk(`CTL_RD_OFS, ctl(0, 1, 0, 0, 1), "ctl wake gone");
        $display("Test wait and wake done");
        axi_write(`INT_CLR_OFS, 32'h0000_000F);
        rd_chk(`INT_STAT_OFS, 32'h0, "int status clear");
        axi_write(`INT_EN_OFS, 32'h0000_0002);
        fatal_err <= 1'b1;
        @(posedge aclk);
        fatal_err <= 1'b0;
        rd_chk(`CTL_RD_OFS, ctl(0, 1, 0, 1, 0), "ctl dead");
        check("irq dead", 32'h1, {31'h0, irq});
        axi_write(`INT_EN_OFS, 32'h0);
        @(posedge aclk);
        check("irq masked", 32'h0, {31'h0, irq});
        axi_write(`INT_EN_OFS, 32'h0000_0002);
        @(posedge aclk);
        check("irq unmasked", 32'h1, {31'h0, irq});
        axi_write(`INT_CLR_OFS, 32'h0000_0002);
        @(posedge aclk);
        check("irq cleared", 32'h0, {31'h0, irq});
        axi_write(`CTL_CLR_OFS, 32'h0000_8000);
        rd_chk(`CTL_RD_OFS, ctl(0, 0, 0, 0, 0), "ctl dead off");
        axi_write(`CTL_SET_OFS, 32'h8000_8000);
        soft_reset <= 1'b1;
        @(posedge aclk);
        soft_reset <= 1'b0;
        @(posedge aclk);
        rd_chk(`CTL_SET_OFS, 32'h0, "ctl soft reset");
        rd_chk(`INT_EN_OFS, 32'h0000_0002, "int enable kept");
        $display("Test dead, irq and soft reset done");
        conclude();
    end
endmodule
